/* File: bench/tb_periph_disable_write_lock.sv */
/*
 * tb_periph_disable_write_lock: self-checking bench for pdwl_top.
 * Assumes the design package, lock interface and modules compile first.
 */
`timescale 1ns/1ps
module tb_periph_disable_write_lock;
	localparam logic [31:0] K1 = 32'ha5a5_0f0f;
	localparam logic [31:0] K2 = 32'h5a5a_f0f0;
	localparam logic [31:0] LOCK_ON = 32'h0000_1000;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic key_wr = 1'b0;
	logic [31:0] key_data = 32'h0;
	logic cfg_wr = 1'b0;
	logic [31:0] cfg_wdata = 32'h0;
	logic set_once_nv = 1'b0;
	logic pd_wr = 1'b0;
	logic [1:0] pd_sel = 2'h0;
	logic [31:0] pd_wdata = 32'h0;
	logic [31:0] config_control_reg;
	logic [127:0] periph_disable_regs;
	logic pd_wr_ack;
	logic unlocked_flag;
	int num_errors = 0;
	int check_count = 0;

	pdwl_top dut_u (.mclk(mclk), .rst(rst), .key_wr(key_wr), .key_data(key_data),
		.key1_val(K1), .key2_val(K2), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
		.set_once_nv(set_once_nv), .pd_wr(pd_wr), .pd_sel(pd_sel), .pd_wdata(pd_wdata),
		.config_control_reg(config_control_reg), .periph_disable_regs(periph_disable_regs),
		.pd_wr_ack(pd_wr_ack), .unlocked_flag(unlocked_flag));

	initial begin
		forever #4 mclk = ~mclk;
	end

	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic key(input logic [31:0] v);
		@(negedge mclk);
		key_wr = 1'b1;
		key_data = v;
		@(negedge mclk);
		key_wr = 1'b0;
	endtask : key

	// lock shows on the register two edges after the strobe
	task automatic cfg(input logic [31:0] v);
		@(negedge mclk);
		cfg_wr = 1'b1;
		cfg_wdata = v;
		@(negedge mclk);
		cfg_wr = 1'b0;
		repeat (2) @(negedge mclk);
	endtask : cfg

	task automatic pd(input logic [1:0] s, input logic [31:0] v, input logic [31:0] exp);
		@(negedge mclk);
		pd_wr = 1'b1;
		pd_sel = s;
		pd_wdata = v;
		@(negedge mclk);
		pd_wr = 1'b0;
		chk(128'(pd_wr_ack), 128'h1);
		chk(128'(periph_disable_regs[32*s +: 32]), 128'(exp));
	endtask : pd

	task automatic unlock(input logic exp_open);
		key(K1);
		key(K2);
		repeat (2) @(negedge mclk);
		chk(128'(unlocked_flag), 128'(exp_open));
	endtask : unlock

	task automatic do_reset(input logic nv);
		@(negedge mclk);
		rst = 1'b1;
		set_once_nv = nv;
		repeat (10) @(negedge mclk);
		rst = 1'b0;
		repeat (2) @(negedge mclk);
		chk(128'(config_control_reg), 128'h0);
		chk(periph_disable_regs, 128'h0);
	endtask : do_reset

	task automatic t_open_writes;
		do_reset(1'b0);
		pd(2'h0, 32'hdead_beef, 32'hdead_beef);
		pd(2'h3, 32'hffff_ffff, 32'hffff_ffff);
	endtask : t_open_writes

	// a wrong second key must abort the sequence
	task automatic t_no_sequence;
		cfg(LOCK_ON);
		chk(128'(config_control_reg), 128'h0);
		key(K1);
		key(32'h0000_0001);
		cfg(LOCK_ON);
		chk(128'(config_control_reg), 128'h0);
		pd(2'h1, 32'h0000_00aa, 32'h0000_00aa);
		// a granted window lapses if no lock write follows in time
		unlock(1'b1);
		repeat (20) @(negedge mclk);
		chk(128'(unlocked_flag), 128'h0);
		cfg(LOCK_ON);
		chk(128'(config_control_reg), 128'h0);
	endtask : t_no_sequence

	task automatic t_lock_and_clear;
		unlock(1'b1);
		cfg(LOCK_ON);
		chk(128'(config_control_reg), 128'(LOCK_ON));
		pd(2'h0, 32'h1111_1111, 32'hdead_beef);
		unlock(1'b1);
		cfg(32'h0);
		chk(128'(config_control_reg), 128'h0);
		pd(2'h0, 32'h1111_1111, 32'h1111_1111);
	endtask : t_lock_and_clear

	task automatic t_one_way;
		do_reset(1'b1);
		set_once_nv = 1'b0;
		unlock(1'b1);
		cfg(LOCK_ON);
		chk(128'(config_control_reg), 128'(LOCK_ON));
		unlock(1'b0);
		cfg(32'h0);
		chk(128'(config_control_reg), 128'(LOCK_ON));
		pd(2'h2, 32'h0000_5555, 32'h0);
		do_reset(1'b0);
		pd(2'h2, 32'h0000_5555, 32'h0000_5555);
	endtask : t_one_way

	task automatic finish_test;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test

	initial begin
		t_open_writes();
		t_no_sequence();
		t_lock_and_clear();
		t_one_way();
		finish_test();
	end

	initial begin
		repeat (5000) @(posedge mclk);
		num_errors++;
		finish_test();
	end
endmodule : tb_periph_disable_write_lock

/* File: include/pdwl_lock_if.sv */
/*
 * pdwl_lock_if: lock state passed from the lock core to the register bank.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface pdwl_lock_if;
	logic lock;
	logic set_once;
	logic unlocked;
	modport core (output lock, output set_once, output unlocked);
	modport bank (input lock, input set_once, input unlocked);
endinterface : pdwl_lock_if

/* File: include/pdwl_pkg.sv */
/*
 * pdwl_pkg: constants for the peripheral-disable write lock block.
 * Assumes a single system clock and a synchronous active-high reset.
 */
package pdwl_pkg;
	localparam int unsigned LOCK_BIT_POS = 12;
	localparam int unsigned SET_ONCE_BIT_POS = 28;
	localparam int unsigned PD_REG_COUNT = 4;
	localparam int unsigned PD_REG_WIDTH = 32;
	localparam int unsigned CFG_WIDTH = 32;
	localparam logic [PD_REG_WIDTH-1:0] PD_REG_RESET = 32'h0000_0000;
	localparam logic LOCK_RESET = 1'b0;
	localparam logic SET_ONCE_RESET = 1'b0;
	// one less than the cycles a granted unlock stays open before it lapses
	localparam logic [3:0] UNLOCK_WINDOW_CYCLES = 4'hf;
	typedef enum logic [1:0] {
		PDWL_UNL_IDLE,
		PDWL_UNL_KEY1,
		PDWL_UNL_OPEN
	} pdwl_unl_state_t;
endpackage : pdwl_pkg

/* File: src/pdwl_lock_core.sv */
/*
 * pdwl_lock_core: unlock sequence checker and lock bit.
 * Assumes key writes come from logic on mclk; one key per cycle at most.
 */
`timescale 1ns/1ps
module pdwl_lock_core (
	input wire logic mclk,
	input wire logic rst,
	input wire logic key_wr,
	input wire logic [31:0] key_data,
	input wire logic [31:0] key1_val,
	input wire logic [31:0] key2_val,
	input wire logic lock_wr,
	input wire logic lock_wdata,
	input wire logic set_once_nv,
	pdwl_lock_if.core lk
);
	pdwl_pkg::pdwl_unl_state_t unl_q;
	logic [3:0] win_q;
	logic lock_q;
	logic set_once_q;
	logic load_done_q;
	logic open_ok;

	// one-way mode with the lock set refuses the whole unlock sequence
	assign open_ok = !(set_once_q && lock_q);

	// option caught once after reset release, then frozen
	always_ff @(posedge mclk) begin
		if (rst) begin
			set_once_q <= pdwl_pkg::SET_ONCE_RESET;
			load_done_q <= 1'b0;
		end else if (!load_done_q) begin
			set_once_q <= set_once_nv;
			load_done_q <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			unl_q <= pdwl_pkg::PDWL_UNL_IDLE;
			win_q <= 4'h0;
		end else begin
			case (unl_q)
				pdwl_pkg::PDWL_UNL_IDLE: begin
					if (key_wr && key_data == key1_val && open_ok)
						unl_q <= pdwl_pkg::PDWL_UNL_KEY1;
				end
				pdwl_pkg::PDWL_UNL_KEY1: begin
					if (key_wr && key_data == key2_val && open_ok) begin
						unl_q <= pdwl_pkg::PDWL_UNL_OPEN;
						win_q <= pdwl_pkg::UNLOCK_WINDOW_CYCLES;
					end else if (key_wr || lock_wr) begin
						unl_q <= pdwl_pkg::PDWL_UNL_IDLE;
					end
				end
				pdwl_pkg::PDWL_UNL_OPEN: begin
					// a lock write consumes the session
					if (lock_wr || win_q == 4'h0)
						unl_q <= pdwl_pkg::PDWL_UNL_IDLE;
					win_q <= win_q - 4'h1;
				end
				default: unl_q <= pdwl_pkg::PDWL_UNL_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			lock_q <= pdwl_pkg::LOCK_RESET;
		end else if (lock_wr && unl_q == pdwl_pkg::PDWL_UNL_OPEN) begin
			if (lock_wdata || !(set_once_q && lock_q))
				lock_q <= lock_wdata;
		end
	end

	assign lk.lock = lock_q;
	assign lk.set_once = set_once_q;
	assign lk.unlocked = (unl_q == pdwl_pkg::PDWL_UNL_OPEN);

	no_change_locked_a: assert property (@(posedge mclk) disable iff (rst)
		(unl_q != pdwl_pkg::PDWL_UNL_OPEN) |=> $stable(lock_q) || $past(rst))
		else $error("lock changed without unlock");
	set_once_hold_a: assert property (@(posedge mclk) disable iff (rst)
		(set_once_q && lock_q && load_done_q) |=> lock_q)
		else $error("set-once lock cleared");
	unlock_refused_a: assert property (@(posedge mclk) disable iff (rst)
		(set_once_q && lock_q && load_done_q) |=> unl_q != pdwl_pkg::PDWL_UNL_OPEN)
		else $error("unlock opened in one-way mode");
	option_frozen_a: assert property (@(posedge mclk) disable iff (rst)
		load_done_q |=> $stable(set_once_q))
		else $error("option changed at run time");
	reset_clears_a: assert property (@(posedge mclk)
		rst |=> !lock_q && unl_q == pdwl_pkg::PDWL_UNL_IDLE)
		else $error("reset did not clear lock");
	lock_clear_c: cover property (@(posedge mclk) disable iff (rst)
		lock_q ##1 !lock_q);
	one_way_c: cover property (@(posedge mclk) disable iff (rst)
		set_once_q && lock_q && key_wr);
endmodule : pdwl_lock_core

/* File: src/pdwl_top.sv */
/*
 * pdwl_top: peripheral-disable registers guarded by a write lock.
 * Assumes writes arrive as one-cycle strobes from bus logic on mclk.
 */
// Summary of operation
// - locked writes complete but change nothing
// - lock bit twelve of config control
// - lock changes only after unlock sequence
// - one-way option stops lock clearing
// - one-way and locked: unlock does nothing
// - only reset clears one-way lock
`timescale 1ns/1ps
module pdwl_top (
	input wire logic mclk,
	input wire logic rst,
	input wire logic key_wr,
	input wire logic [31:0] key_data,
	input wire logic [31:0] key1_val,
	input wire logic [31:0] key2_val,
	input wire logic cfg_wr,
	input wire logic [31:0] cfg_wdata,
	input wire logic set_once_nv,
	input wire logic pd_wr,
	input wire logic [1:0] pd_sel,
	input wire logic [31:0] pd_wdata,
	output logic [31:0] config_control_reg,
	output logic [127:0] periph_disable_regs,
	output logic pd_wr_ack,
	output logic unlocked_flag
);
	pdwl_lock_if lk ();
	logic [31:0] pd_q [pdwl_pkg::PD_REG_COUNT];
	logic [31:0] cfg_q;
	logic ack_q;
	logic unl_q;

	pdwl_lock_core u_core (
		.mclk(mclk),
		.rst(rst),
		.key_wr(key_wr),
		.key_data(key_data),
		.key1_val(key1_val),
		.key2_val(key2_val),
		.lock_wr(cfg_wr),
		.lock_wdata(cfg_wdata[pdwl_pkg::LOCK_BIT_POS]),
		.set_once_nv(set_once_nv),
		.lk(lk)
	);

	genvar g;
	generate
		for (g = 0; g < pdwl_pkg::PD_REG_COUNT; g++) begin : g_pd
			always_ff @(posedge mclk) begin
				if (rst)
					pd_q[g] <= pdwl_pkg::PD_REG_RESET;
				else if (pd_wr && pd_sel == 2'(g) && !lk.lock)
					pd_q[g] <= pd_wdata;
			end
			assign periph_disable_regs[g*32 +: 32] = pd_q[g];
		end
	endgenerate

	// ack regardless of lock so the write looks normal
	always_ff @(posedge mclk) begin
		if (rst)
			ack_q <= 1'b0;
		else
			ack_q <= pd_wr;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cfg_q <= 32'h0000_0000;
			unl_q <= 1'b0;
		end else begin
			cfg_q <= 32'h0000_0000;
			cfg_q[pdwl_pkg::LOCK_BIT_POS] <= lk.lock;
			unl_q <= lk.unlocked;
		end
	end

	assign config_control_reg = cfg_q;
	assign pd_wr_ack = ack_q;
	assign unlocked_flag = unl_q;

	locked_write_a: assert property (@(posedge mclk) disable iff (rst)
		(pd_wr && lk.lock) |=> $stable(periph_disable_regs) && pd_wr_ack)
		else $error("locked write changed register");
	open_write_a: assert property (@(posedge mclk) disable iff (rst)
		(pd_wr && !lk.lock && pd_sel == 2'h0) |=> periph_disable_regs[31:0] == $past(pd_wdata))
		else $error("unlocked write lost");
	lock_visible_a: assert property (@(posedge mclk) disable iff (rst)
		lk.lock |=> config_control_reg[12])
		else $error("lock bit not shown");
	locked_wr_c: cover property (@(posedge mclk) disable iff (rst) pd_wr && lk.lock);
	open_wr_c: cover property (@(posedge mclk) disable iff (rst) pd_wr && !lk.lock);
endmodule : pdwl_top
